// ==== core/lpl_top.sv ====
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`default_nettype none
module lpl_top #(
  parameter int TICK_CYCLES = lpl_pkg::TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire lpl_pkg::lpl_ahb_req_type ahb_req,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  import lpl_pkg::*;

  logic [15:0] din_reg;
  logic [15:0] ana_a_reg;
  logic [15:0] ana_b_reg;
  logic [15:0] ana_c_reg;
  logic [15:0] cfg_reg;
  logic [31:0] t_pulse_reg;
  logic [31:0] t_on_reg;
  logic [31:0] t_off_reg;
  logic [31:0] t_high_reg;
  logic [31:0] t_low_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic restart_reg;
  logic [31:0] div_reg;
  logic tick;
  logic [7:0] mem;
  logic [7:0] clr;
  logic [15:0] opmask;
  logic [15:0] fanmask;
  logic res_and, res_or, res_xor, res_not, res_copy, res_mux;
  logic res_cmp;
  logic [15:0] fan;
  logic out_pulse, out_on, out_off;
  logic cap_reg, cap_prev_reg;
  logic sc_reg;
  logic [15:0] cnt_reg;
  logic cnt_prev_reg;
  logic hyst_reg;
  logic edge_reg, edge_prev_reg;
  logic [31:0] tr_cnt_reg;
  logic [15:0] asel;
  logic [16:0] sum;
  logic [15:0] diff;
  logic [31:0] prod;
  logic [15:0] quot;
  logic [31:0] dout;
  logic [31:0] rdata;
  lpl_rel_type rel;

  typedef enum logic [1:0] {TR_IDLE, TR_HIGH, TR_LOW} lpl_train_type;
  lpl_train_type tr_state_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Mask with the lowest n bits set, n between 0 and 16.
  function automatic logic [15:0] low_mask(input logic [4:0] n);
    logic [16:0] m;
    m = (17'h0_0001 << n) - 17'h0_0001;
    return m[15:0];
  endfunction : low_mask

  // Four BCD digits to a binary magnitude.
  function automatic logic [15:0] bcd_to_mag(input logic [15:0] g);
    logic [15:0] v;
    v = 16'(g[15:12]) * 16'd1000 + 16'(g[11:8]) * 16'd100;
    v = v + 16'(g[7:4]) * 16'd10 + 16'(g[3:0]);
    return v;
  endfunction : bcd_to_mag

  // Binary magnitude to four BCD digits; above 9999 it saturates.
  function automatic logic [15:0] mag_to_bcd(input logic [15:0] m);
    logic [15:0] v;
    v = (m > BCD_MAX) ? BCD_MAX : m;
    return {4'(v / 16'd1000), 4'((v / 16'd100) % 16'd10),
            4'((v / 16'd10) % 16'd10), 4'(v % 16'd10)};
  endfunction : mag_to_bcd

  // The bus slave never inserts wait states and never reports an error.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture; write data lands in the following data phase.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else if (hready) begin
      wr_pend_reg <= ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hwrite;
      wr_addr_reg <= ahb_req.haddr[7:0];
    end
  end

  // Writable registers; writes to read-only or unmapped offsets vanish.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      din_reg <= DIN_RST;
      ana_a_reg <= ANA_RST;
      ana_b_reg <= ANA_RST;
      ana_c_reg <= ANA_RST;
      cfg_reg <= CFG_RST;
      t_pulse_reg <= TIME_RST;
      t_on_reg <= TIME_RST;
      t_off_reg <= TIME_RST;
      t_high_reg <= TIME_RST;
      t_low_reg <= TIME_RST;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        A_DIN: din_reg <= hwdata[15:0];
        A_ANA_A: ana_a_reg <= hwdata[15:0];
        A_ANA_B: ana_b_reg <= hwdata[15:0];
        A_ANA_C: ana_c_reg <= hwdata[15:0];
        A_CFG: cfg_reg <= {hwdata[15:4], 1'b0, hwdata[2:0]};
        A_T_PULSE: t_pulse_reg <= hwdata;
        A_T_ON: t_on_reg <= hwdata;
        A_T_OFF: t_off_reg <= hwdata;
        A_T_HIGH: t_high_reg <= hwdata;
        A_T_LOW: t_low_reg <= hwdata;
        default: ;
      endcase
    end
  end

  // Writing the restart bit stands in for a shutdown and power-up.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_pend_reg && wr_addr_reg == A_CFG &&
                     hwdata[CFG_RESTART];
    end
  end

  // Primitives whose memory bit is set ignore the restart.
  assign mem = cfg_reg[CFG_MEM +: 8];
  assign clr = {8{restart_reg}} & ~mem;
  assign rel = lpl_rel_type'(cfg_reg[CFG_REL +: 3]);

  // Millisecond logic tick shared by every stateful primitive.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
    end else if (div_reg >= 32'(TICK_CYCLES - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
    end
  end
  assign tick = (div_reg >= 32'(TICK_CYCLES - 1));

  // Width code n-1 selects operand count; codes 0 and 1 both give two.
  assign opmask = (cfg_reg[CFG_WIDTH +: 4] == 4'h0) ? 16'h0003 :
                  low_mask(5'(cfg_reg[CFG_WIDTH +: 4]) + 5'h01);
  assign fanmask = low_mask(5'(cfg_reg[CFG_WIDTH +: 4]) + 5'h01);

  // Plain gates are combinational and reflect the operands at once.
  assign res_and = &(din_reg | ~opmask);
  assign res_or = |(din_reg & opmask);
  assign res_xor = din_reg[DI_XA] ^ din_reg[DI_XB];
  assign res_not = ~din_reg[DI_XA];
  assign res_copy = din_reg[DI_XA];
  assign fan = {16{din_reg[DI_XB]}} & fanmask;
  assign res_mux = din_reg[DI_SEL] ? din_reg[DI_M1] : din_reg[DI_M0];
  assign asel = din_reg[DI_SEL] ? ana_b_reg : ana_a_reg;

  // Arithmetic on unsigned magnitudes; a zero divisor gives all ones.
  assign sum = {1'b0, ana_a_reg} + {1'b0, ana_b_reg};
  assign diff = ana_a_reg - ana_b_reg;
  assign prod = {16'h0000, ana_a_reg} * {16'h0000, ana_b_reg};
  assign quot = (ana_b_reg == '0) ? CNT_MAX : ana_a_reg / ana_b_reg;

  // Comparator relation comes from the configuration word.
  always_comb begin
    case (rel)
      REL_GT: res_cmp = ana_a_reg > ana_b_reg;
      REL_LT: res_cmp = ana_a_reg < ana_b_reg;
      REL_EQ: res_cmp = ana_a_reg == ana_b_reg;
      REL_NE: res_cmp = ana_a_reg != ana_b_reg;
      REL_GE: res_cmp = ana_a_reg >= ana_b_reg;
      REL_LE: res_cmp = ana_a_reg <= ana_b_reg;
      default: res_cmp = 1'b0;
    endcase
  end

  // The pulse, on-delay and off-delay primitives share one timer design in three modes.
  lpl_timer u_pulse (
    .sys_clk(sys_clk), .resetn(resetn), .tick(tick),
    .clr(clr[MB_PULSE]), .mode(TM_PULSE), .trig(din_reg[DI_PULSE]),
    .dur(t_pulse_reg), .out(out_pulse)
  );
  lpl_timer u_on (
    .sys_clk(sys_clk), .resetn(resetn), .tick(tick),
    .clr(clr[MB_ON]), .mode(TM_ON), .trig(din_reg[DI_ON]),
    .dur(t_on_reg), .out(out_on)
  );
  lpl_timer u_off (
    .sys_clk(sys_clk), .resetn(resetn), .tick(tick),
    .clr(clr[MB_OFF]), .mode(TM_OFF), .trig(din_reg[DI_OFF]),
    .dur(t_off_reg), .out(out_off)
  );

  // Capture cell; its clock operand is sampled once per tick.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cap_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else if (clr[MB_CAP]) begin
      cap_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else if (tick) begin
      cap_prev_reg <= din_reg[DI_CAPC];
      if (din_reg[DI_CAPC] && !cap_prev_reg) begin
        cap_reg <= din_reg[DI_CAPD];
      end
    end
  end

  // Set-clear cell; clear is checked first so it wins a tie.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sc_reg <= 1'b0;
    end else if (clr[MB_SC]) begin
      sc_reg <= 1'b0;
    end else if (tick) begin
      if (din_reg[DI_CLR]) begin
        sc_reg <= 1'b0;
      end else if (din_reg[DI_SET]) begin
        sc_reg <= 1'b1;
      end
    end
  end

  // Saturating counter of clock-operand rises.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      cnt_prev_reg <= 1'b0;
    end else if (clr[MB_CNT]) begin
      cnt_reg <= '0;
      cnt_prev_reg <= 1'b0;
    end else if (tick) begin
      cnt_prev_reg <= din_reg[DI_CNTC];
      if (din_reg[DI_CNTR]) begin
        cnt_reg <= '0;
      end else if (din_reg[DI_CNTC] && !cnt_prev_reg &&
                   cnt_reg != CNT_MAX) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // Hysteresis: input A against lower B and upper C.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hyst_reg <= 1'b0;
    end else if (clr[MB_HYST]) begin
      hyst_reg <= 1'b0;
    end else if (tick) begin
      if (ana_a_reg > ana_c_reg) begin
        hyst_reg <= 1'b1;
      end else if (ana_a_reg < ana_b_reg) begin
        hyst_reg <= 1'b0;
      end
    end
  end

  // Pulse train; a zero phase time still lasts one tick so it toggles.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tr_state_reg <= TR_IDLE;
      tr_cnt_reg <= '0;
    end else if (clr[MB_TRAIN]) begin
      tr_state_reg <= TR_IDLE;
      tr_cnt_reg <= '0;
    end else if (tick) begin
      case (tr_state_reg)
        TR_IDLE: begin
          if (din_reg[DI_TRAIN]) begin
            tr_state_reg <= TR_HIGH;
          end
          tr_cnt_reg <= '0;
        end
        TR_HIGH: begin
          if (!din_reg[DI_TRAIN]) begin
            tr_state_reg <= TR_IDLE;
          end else if (tr_cnt_reg + 32'h0000_0001 >= t_high_reg) begin
            tr_state_reg <= TR_LOW;
            tr_cnt_reg <= '0;
          end else begin
            tr_cnt_reg <= tr_cnt_reg + 32'h0000_0001;
          end
        end
        TR_LOW: begin
          if (!din_reg[DI_TRAIN]) begin
            tr_state_reg <= TR_IDLE;
          end else if (tr_cnt_reg + 32'h0000_0001 >= t_low_reg) begin
            tr_state_reg <= TR_HIGH;
            tr_cnt_reg <= '0;
          end else begin
            tr_cnt_reg <= tr_cnt_reg + 32'h0000_0001;
          end
        end
        default: tr_state_reg <= TR_IDLE;
      endcase
    end
  end

  // Rising edge output stands from one tick to the next.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      edge_reg <= 1'b0;
      edge_prev_reg <= 1'b0;
    end else if (tick) begin
      edge_prev_reg <= din_reg[DI_EDGE];
      edge_reg <= din_reg[DI_EDGE] && !edge_prev_reg;
    end
  end

  assign dout = {fan, 1'b0, edge_reg, tr_state_reg == TR_HIGH, hyst_reg,
                 res_cmp, sc_reg, cap_reg, out_off, out_on, out_pulse,
                 res_mux, res_copy, res_not, res_xor, res_or, res_and};

  // Read multiplexer; unmapped offsets read zero.
  always_comb begin
    case (ahb_req.haddr[7:0])
      A_DIN: rdata = {16'h0000, din_reg};
      A_ANA_A: rdata = {16'h0000, ana_a_reg};
      A_ANA_B: rdata = {16'h0000, ana_b_reg};
      A_ANA_C: rdata = {16'h0000, ana_c_reg};
      A_CFG: rdata = {16'h0000, cfg_reg};
      A_T_PULSE: rdata = t_pulse_reg;
      A_T_ON: rdata = t_on_reg;
      A_T_OFF: rdata = t_off_reg;
      A_T_HIGH: rdata = t_high_reg;
      A_T_LOW: rdata = t_low_reg;
      A_DOUT: rdata = dout;
      A_COUNT: rdata = {16'h0000, cnt_reg};
      A_SUM: rdata = {15'h0000, sum};
      A_DIFF: rdata = {16'h0000, diff};
      A_PROD: rdata = prod;
      A_QUOT: rdata = {15'h0000, din_reg[DI_XA], quot};
      A_BCD: rdata = {mag_to_bcd(ana_a_reg), bcd_to_mag(din_reg)};
      A_BIN: rdata = {ana_a_reg, din_reg};
      A_ASEL: rdata = {ana_a_reg, asel};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Read data is registered at the address phase for the data phase.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= '0;
    end else if (hready && ahb_req.hsel && ahb_req.htrans[1] &&
                 !ahb_req.hwrite) begin
      hrdata <= rdata;
    end
  end

  a_sc_clear_wins: assert property (
    tick && !clr[MB_SC] && din_reg[DI_CLR] |=> !sc_reg)
    else $error("Set-clear cell not cleared.");
  a_cnt_saturate: assert property (
    tick && !clr[MB_CNT] && !din_reg[DI_CNTR] && cnt_reg == CNT_MAX
    |=> cnt_reg == CNT_MAX) else $error("Counter passed saturation.");
  a_cnt_clear: assert property (
    tick && !clr[MB_CNT] && din_reg[DI_CNTR] |=> cnt_reg == '0)
    else $error("Counter not cleared.");
  a_hyst_set: assert property (
    tick && !clr[MB_HYST] && ana_a_reg > ana_c_reg |=> hyst_reg)
    else $error("Hysteresis output not set.");
  a_hyst_hold: assert property (
    tick && ana_a_reg <= ana_c_reg && ana_a_reg >= ana_b_reg && !restart_reg
    |=> $stable(hyst_reg)) else $error("Hysteresis output moved in band.");
  a_cap_sample: assert property (
    tick && !clr[MB_CAP] && din_reg[DI_CAPC] && !cap_prev_reg
    |=> cap_reg == $past(din_reg[DI_CAPD]))
    else $error("Capture cell missed clock rise.");
  a_edge_one_tick: assert property (
    $rose(edge_reg) |-> !tick ##1 !tick [*2])
    else $error("Edge output width wrong.");
  a_cnt_retain: assert property (
    restart_reg && mem[MB_CNT] && !tick |=> $stable(cnt_reg))
    else $error("Retained counter lost its value.");
  a_zero_wait: assert property (
    hreadyout && !hresp) else $error("Slave inserted wait or error.");

  c_cnt_full: cover property (cnt_reg == CNT_MAX);
  c_train_run: cover property (tr_state_reg == TR_LOW);
  c_restart_mem: cover property (restart_reg && mem != 8'h00);
endmodule : lpl_top
`default_nettype wire

// ==== core/lpl_pkg.sv ====
`default_nettype none
package lpl_pkg;
  // Register byte offsets.
  localparam logic [7:0] A_DIN = 8'h00;
  localparam logic [7:0] A_ANA_A = 8'h04;
  localparam logic [7:0] A_ANA_B = 8'h08;
  localparam logic [7:0] A_ANA_C = 8'h0c;
  localparam logic [7:0] A_CFG = 8'h10;
  localparam logic [7:0] A_T_PULSE = 8'h14;
  localparam logic [7:0] A_T_ON = 8'h18;
  localparam logic [7:0] A_T_OFF = 8'h1c;
  localparam logic [7:0] A_T_HIGH = 8'h20;
  localparam logic [7:0] A_T_LOW = 8'h24;
  localparam logic [7:0] A_DOUT = 8'h28;
  localparam logic [7:0] A_COUNT = 8'h2c;
  localparam logic [7:0] A_SUM = 8'h30;
  localparam logic [7:0] A_DIFF = 8'h34;
  localparam logic [7:0] A_PROD = 8'h38;
  localparam logic [7:0] A_QUOT = 8'h3c;
  localparam logic [7:0] A_BCD = 8'h40;
  localparam logic [7:0] A_BIN = 8'h44;
  localparam logic [7:0] A_ASEL = 8'h48;
  // Reset values.
  localparam logic [15:0] CFG_RST = 16'h0010;
  localparam logic [15:0] DIN_RST = 16'h0000;
  localparam logic [15:0] ANA_RST = 16'h0000;
  localparam logic [31:0] TIME_RST = 32'h0000_0000;
  // Configuration word fields.
  localparam int CFG_REL = 0;
  localparam int CFG_RESTART = 3;
  localparam int CFG_WIDTH = 4;
  localparam int CFG_MEM = 8;
  // Digital operand bits.
  localparam int DI_XA = 0;
  localparam int DI_XB = 1;
  localparam int DI_M0 = 2;
  localparam int DI_M1 = 3;
  localparam int DI_SEL = 4;
  localparam int DI_PULSE = 5;
  localparam int DI_ON = 6;
  localparam int DI_OFF = 7;
  localparam int DI_CAPD = 8;
  localparam int DI_CAPC = 9;
  localparam int DI_SET = 10;
  localparam int DI_CLR = 11;
  localparam int DI_CNTC = 12;
  localparam int DI_CNTR = 13;
  localparam int DI_TRAIN = 14;
  localparam int DI_EDGE = 15;
  // Memory field bits, one per stateful primitive except the edge detector.
  localparam int MB_PULSE = 0;
  localparam int MB_ON = 1;
  localparam int MB_OFF = 2;
  localparam int MB_CAP = 3;
  localparam int MB_SC = 4;
  localparam int MB_CNT = 5;
  localparam int MB_HYST = 6;
  localparam int MB_TRAIN = 7;
  // Limits and timing.
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] BCD_MAX = 16'h270f;
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;

  typedef enum logic [2:0] {
    REL_GT, REL_LT, REL_EQ, REL_NE, REL_GE, REL_LE
  } lpl_rel_type;
  typedef enum logic [1:0] {TM_PULSE, TM_ON, TM_OFF} lpl_tmode_type;
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
  } lpl_ahb_req_type;
endpackage : lpl_pkg
`default_nettype wire

// ==== core/lpl_timer.sv ====
`default_nettype none
// Millisecond timer shared by the pulse, on-delay and off-delay primitives.
module lpl_timer (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic clr,
  input wire lpl_pkg::lpl_tmode_type mode,
  input wire logic trig,
  input wire logic [31:0] dur,
  output logic out
);
  import lpl_pkg::*;
  logic prev_reg;
  logic [31:0] cnt_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // State moves only on the logic tick or the restart clear, so durations count in ticks.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_reg <= 1'b0;
      cnt_reg <= '0;
      out <= 1'b0;
    end else if (clr) begin
      prev_reg <= 1'b0;
      cnt_reg <= '0;
      out <= 1'b0;
    end else if (tick) begin
      prev_reg <= trig;
      case (mode)
        TM_PULSE: begin
          if (trig && !prev_reg) begin
            out <= (dur != '0);
            cnt_reg <= dur;
          end else if (out) begin
            if (cnt_reg <= 32'h0000_0001) begin
              out <= 1'b0;
            end else begin
              cnt_reg <= cnt_reg - 32'h0000_0001;
            end
          end
        end
        TM_ON: begin
          if (!trig) begin
            out <= 1'b0;
            cnt_reg <= '0;
          end else if (cnt_reg >= dur) begin
            out <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        TM_OFF: begin
          if (trig) begin
            out <= 1'b1;
            cnt_reg <= '0;
          end else if (cnt_reg >= dur) begin
            out <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
          end
        end
        default: out <= 1'b0;
      endcase
    end
  end

  a_pulse_start: assert property (
    tick && !clr && mode == TM_PULSE && trig && !prev_reg && dur != '0
    |=> out) else $error("Pulse did not start on rising input.");
  a_ondly_drop: assert property (
    tick && !clr && mode == TM_ON && !trig |=> !out)
    else $error("On-delay output stayed high with input low.");
  a_offdly_hold: assert property (
    tick && !clr && mode == TM_OFF && trig |=> out)
    else $error("Off-delay output low while input high.");
endmodule : lpl_timer
`default_nettype wire

// ==== tb/lpl_testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import lpl_pkg::*;
  localparam int TC = 4;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  lpl_ahb_req_type req = '0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int fail_count = 0;
  int checks_done = 0;
  // Logic table: configuration word, operand word, expected gate outputs.
  logic [15:0] lcfg [5] = '{16'h0010, 16'h00f0, 16'h00f0, 16'h0000, 16'h0000};
  logic [15:0] ldin [5] = '{16'h0003, 16'h0ffe, 16'hffff, 16'h0001, 16'h0012};
  logic [31:0] lexp [5] = '{32'h0003_0013, 32'hffff_002e, 32'hffff_0033,
    32'h0000_0016, 32'h0001_000e};
  // Comparator result for A=100, B=7, indexed by relation code.
  logic [5:0] rel_exp = 6'b011001;

  // Free-running clock, 4 ns period.
  always #2 sys_clk = ~sys_clk;

  lpl_top #(.TICK_CYCLES(TC)) dut (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ahb_req(req),
    .hready(hreadyout),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp)
  );

  // Prints the verdict once and stops the run.
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  // Case equality so an unknown never counts as a match.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  // One single AHB-Lite word transfer; entered just after a rising edge.
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
    req <= '{1'b1, {24'h00_0000, a}, 2'b10, w, 3'b010};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    req.htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask : wr

  // Reads a register and compares the masked bits.
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0000_0000, r);
    chk(r & m, e);
  endtask : rd

  // Idle gaps let the slow logic tick (one tick every TC clocks) land.
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // A hang ends the run with a counted mismatch.
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(A_CFG, 32'hffff_ffff, 32'h0000_0010);
    rd(A_COUNT, 32'hffff_ffff, 32'h0000_0000);
    rd(8'h4c, 32'hffff_ffff, 32'h0000_0000);
    chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    for (int i = 0; i < 5; i++) begin
      wr(A_CFG, {16'h0000, lcfg[i]});
      wr(A_DIN, {16'h0000, ldin[i]});
      rd(A_DOUT, 32'hffff_003f, lexp[i]);
    end
    // Arithmetic and conversions on A=100, B=7 and operands 0x1234.
    wr(A_ANA_A, 32'h0000_0064);
    wr(A_ANA_B, 32'h0000_0007);
    wr(A_DIN, 32'h0000_1234);
    rd(A_SUM, 32'hffff_ffff, 32'h0000_006b);
    rd(A_DIFF, 32'hffff_ffff, 32'h0000_005d);
    rd(A_PROD, 32'hffff_ffff, 32'h0000_02bc);
    rd(A_QUOT, 32'hffff_ffff, 32'h0000_000e);
    rd(A_BCD, 32'hffff_ffff, 32'h0100_04d2);
    rd(A_BIN, 32'hffff_ffff, 32'h0064_1234);
    rd(A_ASEL, 32'hffff_ffff, 32'h0064_0007);
    wr(A_DIN, 32'h0000_0001);
    rd(A_QUOT, 32'h0001_0000, 32'h0001_0000);
    for (int i = 0; i < 6; i++) begin
      wr(A_CFG, i);
      rd(A_DOUT, 32'h0000_0800, {20'h0, rel_exp[i], 11'h0});
    end
    wr(A_ANA_B, 32'h0000_0000);
    rd(A_QUOT, 32'h0000_ffff, 32'h0000_ffff);
    // Hysteresis: clear below B, hold in band, set above C.
    wr(A_ANA_B, 32'h0000_0078);
    wr(A_ANA_C, 32'h0000_0096);
    idle(8);
    rd(A_DOUT, 32'h0000_1000, 32'h0000_0000);
    wr(A_ANA_B, 32'h0000_0014);
    idle(8);
    rd(A_DOUT, 32'h0000_1000, 32'h0000_0000);
    wr(A_ANA_C, 32'h0000_0032);
    idle(8);
    rd(A_DOUT, 32'h0000_1000, 32'h0000_1000);
    wr(A_ANA_C, 32'h0000_0096);
    idle(8);
    rd(A_DOUT, 32'h0000_1000, 32'h0000_1000);
    wr(A_ANA_B, 32'h0000_0078);
    idle(8);
    rd(A_DOUT, 32'h0000_1000, 32'h0000_0000);
    // Counter: clear, three rises, then a restart kept by the memory bit and one without it.
    wr(A_DIN, 32'h0000_2000);
    idle(8);
    for (int i = 0; i < 3; i++) begin
      wr(A_DIN, 32'h0000_1000);
      idle(8);
      wr(A_DIN, 32'h0000_0000);
      idle(8);
    end
    rd(A_COUNT, 32'hffff_ffff, 32'h0000_0003);
    wr(A_CFG, 32'h0000_2018);
    idle(8);
    rd(A_COUNT, 32'hffff_ffff, 32'h0000_0003);
    wr(A_CFG, 32'h0000_0018);
    idle(8);
    rd(A_COUNT, 32'hffff_ffff, 32'h0000_0000);
    // Set-clear cell and capture cell.
    wr(A_DIN, 32'h0000_0400);
    idle(8);
    rd(A_DOUT, 32'h0000_0400, 32'h0000_0400);
    wr(A_DIN, 32'h0000_0c00);
    idle(8);
    rd(A_DOUT, 32'h0000_0400, 32'h0000_0000);
    wr(A_DIN, 32'h0000_0100);
    idle(8);
    wr(A_DIN, 32'h0000_0300);
    idle(8);
    wr(A_DIN, 32'h0000_0000);
    idle(8);
    rd(A_DOUT, 32'h0000_0200, 32'h0000_0200);
    // Pulse of three ticks after a rise, then gone.
    wr(A_T_PULSE, 32'h0000_0003);
    wr(A_DIN, 32'h0000_0020);
    idle(5);
    rd(A_DOUT, 32'h0000_0040, 32'h0000_0040);
    idle(16);
    rd(A_DOUT, 32'h0000_0040, 32'h0000_0000);
    // On-delay of three ticks, then a drop with the input.
    wr(A_T_ON, 32'h0000_0003);
    wr(A_DIN, 32'h0000_0040);
    idle(2);
    rd(A_DOUT, 32'h0000_0080, 32'h0000_0000);
    idle(16);
    rd(A_DOUT, 32'h0000_0080, 32'h0000_0080);
    wr(A_DIN, 32'h0000_0000);
    idle(8);
    rd(A_DOUT, 32'h0000_0080, 32'h0000_0000);
    // Off-delay holds three ticks past the fall.
    wr(A_T_OFF, 32'h0000_0003);
    wr(A_DIN, 32'h0000_0080);
    idle(8);
    rd(A_DOUT, 32'h0000_0100, 32'h0000_0100);
    wr(A_DIN, 32'h0000_0000);
    idle(2);
    rd(A_DOUT, 32'h0000_0100, 32'h0000_0100);
    idle(16);
    rd(A_DOUT, 32'h0000_0100, 32'h0000_0000);
    // Pulse train with phases of 100 ticks, then disabled.
    wr(A_T_HIGH, 32'h0000_0064);
    wr(A_T_LOW, 32'h0000_0064);
    wr(A_DIN, 32'h0000_4000);
    idle(8);
    rd(A_DOUT, 32'h0000_2000, 32'h0000_2000);
    idle(400);
    rd(A_DOUT, 32'h0000_2000, 32'h0000_0000);
    idle(400);
    rd(A_DOUT, 32'h0000_2000, 32'h0000_2000);
    wr(A_DIN, 32'h0000_0000);
    idle(8);
    rd(A_DOUT, 32'h0000_2000, 32'h0000_0000);
    // Edge output is seen inside its one tick and gone after it.
    wr(A_DIN, 32'h0000_8000);
    idle(4);
    rd(A_DOUT, 32'h0000_4000, 32'h0000_4000);
    idle(8);
    rd(A_DOUT, 32'h0000_4000, 32'h0000_0000);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
